/* hdl/pmc_defs.svh */
// Register offsets, field positions, reset values and timing defaults of the power-mode controller.
// Included by pmc_ctrl and its bench; holds definitions only.
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Register byte offsets on the Wishbone slave.
`define PMC_OFS_CTRL 8'h00
`define PMC_OFS_IDLE_STOP 8'h04
`define PMC_OFS_STATUS 8'h08

// Control register fields.
`define PMC_CTRL_SRC_LSB 0
`define PMC_CTRL_SRC_MSB 2
`define PMC_CTRL_SLEEP_BIT 4
`define PMC_CTRL_DIV_LSB 19
`define PMC_CTRL_DIV_MSB 20

// Status register fields.
`define PMC_STAT_MODE_LSB 0
`define PMC_STAT_MODE_MSB 1
`define PMC_STAT_SRC_LSB 4
`define PMC_STAT_SRC_MSB 6
`define PMC_STAT_BUSY_BIT 8
`define PMC_STAT_POSC_BIT 9
`define PMC_STAT_SOSC_BIT 10

// Clock source codes.
`define PMC_SRC_FAST 3'h0
`define PMC_SRC_FAST_DIV 3'h1
`define PMC_SRC_PRIMARY 3'h2
`define PMC_SRC_PRIMARY_PLL 3'h3
`define PMC_SRC_SECONDARY 3'h4
`define PMC_SRC_LOW_POWER 3'h5

// Reset values.
`define PMC_RST_SRC 3'h0
`define PMC_RST_DIV 2'h0
`define PMC_RST_SLEEP 1'b0

// Default start-up and lock counts, in system clock cycles.
`define PMC_OSC_START_CYC_DEF 1024
`define PMC_PLL_LOCK_CYC_DEF 2048

`endif

/* hdl/pmc_pkg.sv */
// Types shared by the power-mode controller files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pmc_pkg;

  typedef enum logic [1:0] {
    PMC_RUN,
    PMC_IDLE,
    PMC_SLEEP,
    PMC_WAKE
  } pmc_mode_t;

endpackage

`default_nettype wire

/* hdl/pmc_pb_divider.sv */
// Peripheral bus clock divider: one-cycle tick every 1, 2, 4 or 8 system clock cycles.
// Assumes the divider field comes from a register on the same clock.
`timescale 1ns/1ps
`default_nettype none

module pmc_pb_divider (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic [1:0] div_i,
  // Peripheral bus clock edge
  output logic tick_o
);

  logic [2:0] cnt;
  logic [2:0] limit;

  // Encoding 00, 01, 10, 11 gives ratios of one, two, four and eight.
  assign limit = 3'((4'h1 << div_i) - 4'h1); // R16

  // A stopped divider restarts from zero so the first tick after a stop is a full period late at most.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      cnt <= 3'h0;
      tick_o <= 1'b0;
    end
    else if (cnt >= limit)
    begin
      cnt <= 3'h0;
      tick_o <= 1'b1; // R15
    end
    else
    begin
      cnt <= cnt + 3'h1;
      tick_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* hdl/pmc_ctrl.sv */
// Power-mode controller: Run, Idle and Sleep sequencing, clock gating, peripheral bus divider.
// Assumes CPU, interrupt controller and watchdog sit on clk_i; registers reached over classic Wishbone.
//
// Behaviour
// R1 - Wait instruction with sleep select clear enters Idle, stopping only the CPU clock.
// R2 - Wait instruction with sleep select set enters Sleep instead.
// R3 - Idle keeps the system clock source running for peripherals and fast exit.
// R4 - In Idle, peripherals with their idle-stop bit set halt; others continue.
// R5 - Idle ends on enabled interrupt only above current CPU priority.
// R6 - Watchdog time-out also ends Idle.
// R7 - Any device reset ends Sleep or Idle.
// R8 - Sleep stops CPU, system clock source and system-clocked peripherals.
// R9 - Sleep ends on higher-priority interrupt from a running source, or watchdog time-out.
// R10 - Low-priority wake in Sleep restarts peripheral bus clock and enters Idle.
// R11 - Clock-failure monitor is off throughout Sleep.
// R12 - Watchdog is not cleared on Sleep entry and may wake later.
// R13 - Peripherals on external or low-power clocks keep running in Sleep.
// R14 - USB may keep primary or fast oscillator running during Sleep.
// R15 - Two-bit divider sets peripheral bus ratio 1:1, 1:2, 1:4 or 1:8.
// R16 - Divider encoding 00, 01, 10, 11 means one, two, four, eight.
// R17 - USB, interrupt controller, DMA and bus matrix ignore the divider.
// R18 - Peripheral read completes at next peripheral bus edge.
// R19 - Switching to a stopped crystal or PLL source waits start-up and lock; the code skips PLL lock when primary already runs.
// R20 - Run clock selects fast, fast divided, low-power or secondary oscillator.
// R21 - Software picks the largest divider meeting peripheral timing.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.svh"

module pmc_ctrl #(
  parameter int NPERIPH = 8,
  parameter int PRIO_W = 3,
  parameter logic [31:0] SLEEP_RUN_MASK = 32'h0000_0001,
  parameter int OSC_START_CYC = `PMC_OSC_START_CYC_DEF,
  parameter int PLL_LOCK_CYC = `PMC_PLL_LOCK_CYC_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // CPU and interrupt controller
  input wire logic wait_exec_i,
  input wire logic irq_valid_i,
  input wire logic irq_sleep_src_i,
  input wire logic [PRIO_W-1:0] irq_prio_i,
  input wire logic [PRIO_W-1:0] cpu_prio_i,
  input wire logic watchdog_timeout_i,
  input wire logic dev_reset_i,
  input wire logic usb_keep_osc_i,
  // Peripheral read path
  input wire logic pb_rd_req_i,
  output logic pb_rd_ack_o,
  // Clock gating
  output logic cpu_clk_en_o,
  output logic sys_clk_src_en_o,
  output logic sysdom_clk_en_o,
  output logic pb_tick_o,
  output logic [NPERIPH-1:0] periph_clk_en_o,
  output logic fail_mon_en_o,
  output logic [2:0] clk_sel_o,
  output logic [1:0] mode_o
);

  localparam int CNT_W = 16;

  generate
    if (NPERIPH < 1 || NPERIPH > 32 || PRIO_W < 1 || PRIO_W > 8)
    begin : g_bad_params
      $error("pmc_ctrl: NPERIPH must be 1..32 and PRIO_W 1..8");
    end
    if (OSC_START_CYC + PLL_LOCK_CYC >= (1 << CNT_W))
    begin : g_bad_counts
      $error("pmc_ctrl: start-up plus lock count exceeds the counter");
    end
  endgenerate

  pmc_pkg::pmc_mode_t mode;
  pmc_pkg::pmc_mode_t next_mode;
  logic [2:0] req_src;
  logic [2:0] cur_src;
  logic sleep_sel;
  logic [1:0] pb_div;
  logic [NPERIPH-1:0] idle_stop;
  logic posc_on;
  logic sosc_on;
  logic [CNT_W-1:0] osc_cnt;
  logic sw_busy;
  logic sw_wait;
  logic pb_tick;
  logic wb_req;
  logic [31:0] wmask;
  logic [31:0] next_rdata;
  logic wake_prio;
  logic [CNT_W-1:0] start_delay;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wake_prio = irq_valid_i && (irq_prio_i > cpu_prio_i);
  assign sw_busy = req_src != cur_src;

  // Start-up time of a source that must be brought up, zero when it already runs.
  function automatic logic [CNT_W-1:0] delay_of(input logic [2:0] src, input logic p_on, input logic s_on);
    logic [CNT_W-1:0] d;
    d = '0;
    if ((src == `PMC_SRC_PRIMARY || src == `PMC_SRC_PRIMARY_PLL) && !p_on)
      d = CNT_W'(OSC_START_CYC);
    if (src == `PMC_SRC_PRIMARY_PLL && !p_on)
      d = CNT_W'(OSC_START_CYC + PLL_LOCK_CYC);
    if (src == `PMC_SRC_SECONDARY && !s_on)
      d = CNT_W'(OSC_START_CYC);
    return d;
  endfunction

  assign start_delay = delay_of(sw_busy ? req_src : cur_src, posc_on, sosc_on); // R19

  // Wishbone register access.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req && !wb_we_i ? next_rdata : 32'h0000_0000;
    end
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `PMC_OFS_CTRL:
      begin
        next_rdata[`PMC_CTRL_SRC_MSB:`PMC_CTRL_SRC_LSB] = req_src;
        next_rdata[`PMC_CTRL_SLEEP_BIT] = sleep_sel;
        next_rdata[`PMC_CTRL_DIV_MSB:`PMC_CTRL_DIV_LSB] = pb_div;
      end
      `PMC_OFS_IDLE_STOP:
        next_rdata[NPERIPH-1:0] = idle_stop;
      `PMC_OFS_STATUS:
      begin
        next_rdata[`PMC_STAT_MODE_MSB:`PMC_STAT_MODE_LSB] = mode;
        next_rdata[`PMC_STAT_SRC_MSB:`PMC_STAT_SRC_LSB] = cur_src;
        next_rdata[`PMC_STAT_BUSY_BIT] = sw_busy;
        next_rdata[`PMC_STAT_POSC_BIT] = posc_on;
        next_rdata[`PMC_STAT_SOSC_BIT] = sosc_on;
      end
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  // Control and idle-stop registers; unmapped writes are ignored.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_src <= `PMC_RST_SRC;
      sleep_sel <= `PMC_RST_SLEEP;
      pb_div <= `PMC_RST_DIV;
      idle_stop <= '0;
    end
    else if (wb_req && wb_we_i)
    begin
      if (wb_adr_i == `PMC_OFS_CTRL)
      begin
        if (wmask[`PMC_CTRL_SRC_LSB])
          req_src <= wb_dat_i[`PMC_CTRL_SRC_MSB:`PMC_CTRL_SRC_LSB] > `PMC_SRC_LOW_POWER
            ? req_src : wb_dat_i[`PMC_CTRL_SRC_MSB:`PMC_CTRL_SRC_LSB]; // R20
        if (wmask[`PMC_CTRL_SLEEP_BIT])
          sleep_sel <= wb_dat_i[`PMC_CTRL_SLEEP_BIT];
        if (wmask[`PMC_CTRL_DIV_LSB])
          pb_div <= wb_dat_i[`PMC_CTRL_DIV_MSB:`PMC_CTRL_DIV_LSB]; // R15
      end
      if (wb_adr_i == `PMC_OFS_IDLE_STOP)
        idle_stop <= (idle_stop & ~wmask[NPERIPH-1:0]) | (wb_dat_i[NPERIPH-1:0] & wmask[NPERIPH-1:0]);
    end
  end

  // Mode sequencing.
  always_comb
  begin
    next_mode = mode;
    case (mode)
      pmc_pkg::PMC_RUN:
        if (wait_exec_i)
          next_mode = sleep_sel ? pmc_pkg::PMC_SLEEP : pmc_pkg::PMC_IDLE; // R1 R2
      pmc_pkg::PMC_IDLE:
        if (wake_prio || watchdog_timeout_i)
          next_mode = pmc_pkg::PMC_RUN; // R5 R6
      pmc_pkg::PMC_SLEEP:
        if (watchdog_timeout_i || (irq_sleep_src_i && wake_prio))
          next_mode = pmc_pkg::PMC_WAKE; // R9 R12
        else if (irq_sleep_src_i && irq_valid_i)
          next_mode = pmc_pkg::PMC_IDLE; // R10
      pmc_pkg::PMC_WAKE:
        if (osc_cnt == '0)
          next_mode = pmc_pkg::PMC_RUN;
      default:
        next_mode = pmc_pkg::PMC_RUN;
    endcase
    if (dev_reset_i)
      next_mode = pmc_pkg::PMC_RUN; // R7
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode <= pmc_pkg::PMC_RUN; // R7
    else
      mode <= next_mode;
  end

  // Oscillator state, source switching and start-up counting.
  // A switch is only started in Run; a pending one still completes in Idle or Sleep and can share the start-up counter with a wake.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur_src <= `PMC_RST_SRC;
      posc_on <= 1'b0;
      sosc_on <= 1'b0;
      osc_cnt <= '0;
      sw_wait <= 1'b0;
    end
    else
    begin
      if (mode == pmc_pkg::PMC_SLEEP && next_mode == pmc_pkg::PMC_WAKE)
        osc_cnt <= start_delay; // R19
      else if (mode == pmc_pkg::PMC_RUN && sw_busy && !sw_wait)
      begin
        osc_cnt <= start_delay; // R19
        sw_wait <= 1'b1;
      end
      else if (osc_cnt != '0)
        osc_cnt <= osc_cnt - CNT_W'(1);
      else if (sw_wait)
      begin
        cur_src <= req_src; // R20
        sw_wait <= 1'b0;
      end
      if (mode == pmc_pkg::PMC_SLEEP && !usb_keep_osc_i)
        posc_on <= 1'b0; // R8 R14
      else if (osc_cnt == CNT_W'(1) || mode == pmc_pkg::PMC_IDLE)
        posc_on <= posc_on || cur_src == `PMC_SRC_PRIMARY || cur_src == `PMC_SRC_PRIMARY_PLL
          || req_src == `PMC_SRC_PRIMARY || req_src == `PMC_SRC_PRIMARY_PLL;
      if (osc_cnt == CNT_W'(1) && (req_src == `PMC_SRC_SECONDARY || cur_src == `PMC_SRC_SECONDARY))
        sosc_on <= 1'b1;
    end
  end

  // Peripheral bus divider; it stops in Sleep, even when USB keeps the system clock source running.
  pmc_pb_divider u_pb_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(mode != pmc_pkg::PMC_SLEEP),
    .div_i(pb_div),
    .tick_o(pb_tick)
  );

  // Peripheral reads wait for the next peripheral bus edge; up to seven extra cycles at 1:8.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pb_rd_ack_o <= 1'b0;
    else
      pb_rd_ack_o <= pb_rd_req_i && !pb_rd_ack_o && pb_tick; // R18
  end

  // Clock gating outputs, all registered.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cpu_clk_en_o <= 1'b1;
      sys_clk_src_en_o <= 1'b1;
      sysdom_clk_en_o <= 1'b1;
      fail_mon_en_o <= 1'b1;
      pb_tick_o <= 1'b0;
      clk_sel_o <= `PMC_RST_SRC;
      mode_o <= 2'h0;
    end
    else
    begin
      cpu_clk_en_o <= mode == pmc_pkg::PMC_RUN; // R1 R8
      sys_clk_src_en_o <= mode != pmc_pkg::PMC_SLEEP
        || (usb_keep_osc_i && cur_src != `PMC_SRC_SECONDARY && cur_src != `PMC_SRC_LOW_POWER); // R3 R8 R14
      sysdom_clk_en_o <= mode != pmc_pkg::PMC_SLEEP; // R17
      fail_mon_en_o <= mode != pmc_pkg::PMC_SLEEP; // R11
      pb_tick_o <= pb_tick;
      clk_sel_o <= cur_src;
      mode_o <= mode;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPERIPH; gi++)
    begin : g_periph
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          periph_clk_en_o[gi] <= 1'b1;
        else
        begin
          case (mode)
            pmc_pkg::PMC_IDLE:
              periph_clk_en_o[gi] <= !idle_stop[gi]; // R4
            pmc_pkg::PMC_SLEEP:
              periph_clk_en_o[gi] <= SLEEP_RUN_MASK[gi]; // R8 R13
            default:
              periph_clk_en_o[gi] <= 1'b1;
          endcase
        end
      end
    end
  endgenerate

  sequence s_wait_idle;
    mode == pmc_pkg::PMC_RUN && wait_exec_i && !sleep_sel && !dev_reset_i;
  endsequence

  sequence s_wait_sleep;
    mode == pmc_pkg::PMC_RUN && wait_exec_i && sleep_sel && !dev_reset_i;
  endsequence

  property p_idle_entry;
    @(posedge clk_i) disable iff (rst_i)
      s_wait_idle |=> mode == pmc_pkg::PMC_IDLE ##1 (!cpu_clk_en_o && sys_clk_src_en_o);
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("Idle not entered correctly"); // R1

  property p_sleep_entry;
    @(posedge clk_i) disable iff (rst_i)
      s_wait_sleep |=> mode == pmc_pkg::PMC_SLEEP ##1 (!cpu_clk_en_o && !fail_mon_en_o);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("Sleep not entered correctly"); // R2

  property p_idle_stop;
    @(posedge clk_i) disable iff (rst_i)
      mode == pmc_pkg::PMC_IDLE |=> periph_clk_en_o[0] == !$past(idle_stop[0]);
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("Idle-stop gating wrong"); // R4

  property p_idle_hold;
    @(posedge clk_i) disable iff (rst_i)
      mode == pmc_pkg::PMC_IDLE && !wake_prio && !watchdog_timeout_i && !dev_reset_i |=> mode == pmc_pkg::PMC_IDLE;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("Idle left without cause"); // R5

  property p_idle_wake;
    @(posedge clk_i) disable iff (rst_i)
      mode == pmc_pkg::PMC_IDLE && (wake_prio || watchdog_timeout_i) |=> ##1 cpu_clk_en_o;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("Idle wake missed"); // R6

  property p_reset_exit;
    @(posedge clk_i) disable iff (rst_i)
      dev_reset_i |=> mode == pmc_pkg::PMC_RUN;
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("Reset did not end low-power mode"); // R7

  property p_sleep_gate;
    @(posedge clk_i) disable iff (rst_i)
      mode == pmc_pkg::PMC_SLEEP && !usb_keep_osc_i |=> !sys_clk_src_en_o && !sysdom_clk_en_o && !pb_tick;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("Sleep left clocks running"); // R8

  property p_sleep_low_prio;
    @(posedge clk_i) disable iff (rst_i)
      mode == pmc_pkg::PMC_SLEEP && irq_valid_i && irq_sleep_src_i && !wake_prio && !watchdog_timeout_i
        && !dev_reset_i |=> mode == pmc_pkg::PMC_IDLE ##1 !cpu_clk_en_o;
  endproperty
  a_sleep_low_prio: assert property (p_sleep_low_prio) else $error("Low-priority wake not to Idle"); // R10

  property p_pb_read;
    @(posedge clk_i) disable iff (rst_i)
      $rose(pb_rd_req_i) |-> ##[1:8] pb_rd_ack_o;
  endproperty
  a_pb_read: assert property (p_pb_read) else $error("Peripheral read not completed in time"); // R18

endmodule

`default_nettype wire

/* verification/pmc_pb_reader.sv */
// CPU-side peripheral read master used by the power-mode controller bench.
// Assumes the peripheral read handshake of pmc_ctrl on the same system clock.
`timescale 1ns/1ps
`default_nettype none

module pmc_pb_reader (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic start_i,
  output logic done_o,
  output logic [7:0] lat_o,
  // Peripheral read path
  output logic req_o,
  input wire logic ack_i
);
  // The request stays up until the acknowledge is sampled, as a stalled CPU would hold it.
  always_ff @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (rst_i)
    begin
      req_o <= 1'b0;
      lat_o <= 8'h00;
    end
    else if (start_i)
    begin
      req_o <= 1'b1;
      lat_o <= 8'h00;
    end
    else if (req_o && ack_i)
    begin
      req_o <= 1'b0;
      done_o <= 1'b1;
    end
    else if (req_o)
      lat_o <= lat_o + 8'h01;
  end
endmodule

`default_nettype wire

/* verification/pmc_ctrl_tb.sv */
// Self-checking bench for the power-mode controller.
// Assumes pmc_ctrl with shortened start-up counts and the peripheral read master model.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.svh"

module pmc_ctrl_tb;
  logic clk = 1'b0, rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic ack, wait_exec = 1'b0, irq_valid = 1'b0, irq_ssrc = 1'b0, wdog = 1'b0, dev_rst = 1'b0;
  logic usb_keep = 1'b0;
  logic [2:0] irq_prio = 3'h0, cpu_prio = 3'h0, clk_sel;
  logic rd_start = 1'b0, rd_done, rd_req, rd_ack, cpu_en, src_en, sysdom, tick, fmon;
  logic [7:0] rd_lat, periph;
  logic [1:0] mode;
  int n_fail = 0, check_count = 0;

  always #5 clk = ~clk;

  pmc_ctrl #(.OSC_START_CYC(8), .PLL_LOCK_CYC(8)) pmc_ctrl_inst (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wait_exec_i(wait_exec),
    .irq_valid_i(irq_valid), .irq_sleep_src_i(irq_ssrc), .irq_prio_i(irq_prio), .cpu_prio_i(cpu_prio),
    .watchdog_timeout_i(wdog), .dev_reset_i(dev_rst), .usb_keep_osc_i(usb_keep), .pb_rd_req_i(rd_req),
    .pb_rd_ack_o(rd_ack), .cpu_clk_en_o(cpu_en), .sys_clk_src_en_o(src_en), .sysdom_clk_en_o(sysdom),
    .pb_tick_o(tick), .periph_clk_en_o(periph), .fail_mon_en_o(fmon), .clk_sel_o(clk_sel), .mode_o(mode)
  );

  pmc_pb_reader pmc_pb_reader_inst (
    .clk_i(clk), .rst_i(rst), .start_i(rd_start), .done_o(rd_done), .lat_o(rd_lat),
    .req_o(rd_req), .ack_i(rd_ack)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single cycle: the request is held until ack is sampled, then released for a cycle.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    chk("wb_ack", 1, ack);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0000_0000, r);
    chk(what, e, r & m);
  endtask

  task automatic wait_pulse;
    wait_exec <= 1'b1;
    @(posedge clk);
    wait_exec <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic pulse_wdog;
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_regs;
    rdchk("ctrl", `PMC_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk("status", `PMC_OFS_STATUS, 32'h0000_0173, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(`PMC_OFS_CTRL, 32'h0000_0007);
    rdchk("bad_src", `PMC_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic t_idle;
    wr(`PMC_OFS_IDLE_STOP, 32'h0000_00A5);
    wait_pulse();
    chk("mode", pmc_pkg::PMC_IDLE, mode);
    chk("cpu_en", 0, cpu_en);
    chk("src_en", 1, src_en);
    chk("periph", 32'h0000_005A, periph);
    cpu_prio <= 3'h4;
    irq_prio <= 3'h4;
    irq_valid <= 1'b1;
    repeat (4) @(posedge clk);
    chk("mode", pmc_pkg::PMC_IDLE, mode);
    irq_prio <= 3'h5;
    repeat (4) @(posedge clk);
    chk("mode", pmc_pkg::PMC_RUN, mode);
    chk("cpu_en", 1, cpu_en);
    irq_valid <= 1'b0;
    wait_pulse();
    chk("mode", pmc_pkg::PMC_IDLE, mode);
    pulse_wdog();
    chk("mode", pmc_pkg::PMC_RUN, mode);
    $display("test idle done");
  endtask

  task automatic t_sleep;
    int n;
    wr(`PMC_OFS_CTRL, 32'h0000_0010);
    wait_pulse();
    chk("mode", pmc_pkg::PMC_SLEEP, mode);
    chk("src_en", 0, src_en);
    chk("sysdom", 0, sysdom);
    chk("fmon", 0, fmon);
    chk("periph", 32'h0000_0001, periph);
    // A high-priority interrupt from a source that is stopped in Sleep must not wake the device.
    irq_prio <= 3'h6;
    irq_valid <= 1'b1;
    repeat (4) @(posedge clk);
    chk("mode", pmc_pkg::PMC_SLEEP, mode);
    irq_ssrc <= 1'b1;
    irq_prio <= 3'h2;
    repeat (4) @(posedge clk);
    chk("mode", pmc_pkg::PMC_IDLE, mode);
    chk("cpu_en", 0, cpu_en);
    n = 0;
    while (tick !== 1'b1 && n < 10)
    begin
      @(posedge clk);
      n++;
    end
    chk("tick", 1, tick);
    irq_valid <= 1'b0;
    dev_rst <= 1'b1;
    @(posedge clk);
    dev_rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("mode", pmc_pkg::PMC_RUN, mode);
    for (int k = 0; k < 2; k++)
    begin
      usb_keep <= 1'(k);
      wait_pulse();
      chk("mode", pmc_pkg::PMC_SLEEP, mode);
      chk("src_en", 32'(k), src_en);
      if (k == 0)
        pulse_wdog();
      else
        {irq_prio, irq_valid} <= {3'h6, 1'b1};
      n = 0;
      while (mode !== pmc_pkg::PMC_RUN && n < 40)
      begin
        @(posedge clk);
        n++;
      end
      chk("mode", pmc_pkg::PMC_RUN, mode);
      irq_valid <= 1'b0;
    end
    irq_ssrc <= 1'b0;
    usb_keep <= 1'b0;
    wr(`PMC_OFS_CTRL, 32'h0000_0000);
    $display("test sleep done");
  endtask

  task automatic t_div;
    int n;
    for (int d = 0; d < 4; d++)
    begin
      wr(`PMC_OFS_CTRL, 32'(d) << `PMC_CTRL_DIV_LSB);
      n = 0;
      while (tick !== 1'b1 && n < 20)
      begin
        @(posedge clk);
        n++;
      end
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end while (tick !== 1'b1 && n < 20);
      chk("tick_gap", 32'(1 << d), 32'(n));
      chk("sysdom", 1, sysdom);
      rd_start <= 1'b1;
      @(posedge clk);
      rd_start <= 1'b0;
      n = 0;
      while (rd_done !== 1'b1 && n < 30)
      begin
        @(posedge clk);
        n++;
      end
      chk("rd_lat", 1, 32'(rd_lat >= 8'h01 && rd_lat <= 8'(1 << d)));
    end
    $display("test div done");
  endtask

  task automatic t_src;
    logic [2:0] srcs [5];
    int n;
    // Going back to the primary source while it still runs must not wait again.
    srcs = '{`PMC_SRC_PRIMARY, `PMC_SRC_LOW_POWER, `PMC_SRC_SECONDARY, `PMC_SRC_FAST, `PMC_SRC_PRIMARY};
    foreach (srcs[i])
    begin
      wr(`PMC_OFS_CTRL, {29'h0, srcs[i]});
      n = 0;
      while (clk_sel !== srcs[i] && n < 40)
      begin
        @(posedge clk);
        n++;
      end
      chk("clk_sel", srcs[i], clk_sel);
      chk("start_wait", (i == 0 || i == 2), n >= 5);
    end
    // The primary oscillator stops in Sleep, so waking on it must pass through the start-up wait.
    wr(`PMC_OFS_CTRL, 32'h0000_0012);
    wait_pulse();
    chk("mode", pmc_pkg::PMC_SLEEP, mode);
    pulse_wdog();
    chk("mode", pmc_pkg::PMC_WAKE, mode);
    n = 0;
    while (mode !== pmc_pkg::PMC_RUN && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    chk("mode", pmc_pkg::PMC_RUN, mode);
    wr(`PMC_OFS_CTRL, 32'h0000_0000);
    $display("test src done");
  endtask

  task automatic results;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_fail++;
    results();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_idle();
    t_sleep();
    t_div();
    t_src();
    results();
  end
endmodule

`default_nettype wire
